// File: hdl/ccsu_pkg.sv
package ccsu_pkg;
    // Command codes on the decoded command port
    localparam logic [3:0] CMD_NONE = 4'h0;
    localparam logic [3:0] CMD_RESET = 4'h1;
    localparam logic [3:0] CMD_SAVE = 4'h2;
    localparam logic [3:0] CMD_RECALL = 4'h3;
    localparam logic [3:0] CMD_MASK_WR = 4'h4;
    localparam logic [3:0] CMD_MASK_RD = 4'h5;
    localparam logic [3:0] CMD_STATUS_RD = 4'h6;
    localparam logic [3:0] CMD_TRIGGER = 4'h7;
    localparam logic [3:0] CMD_SELF_TEST = 4'h8;
    localparam logic [3:0] CMD_WAIT = 4'h9;
    localparam logic [3:0] CMD_OUTPUT_ON = 4'hA;
    localparam logic [3:0] CMD_INIT = 4'hB;
    localparam logic [3:0] CMD_SET_TRIG = 4'hC;

    // Summary byte bit positions
    localparam int SUM_OPERATION_SUMMARY_BIT_BIT = 7;
    localparam int SUM_MSS_BIT = 6;
    localparam int SUM_ESB_BIT = 5;
    localparam int SUM_MAV_BIT = 4;
    localparam int SUM_QUESTIONABLE_SUMMARY_BIT_BIT = 3;
    localparam int SUM_ERRQ_BIT = 2;

    // Memory slot range
    localparam logic [6:0] SLOT_MIN = 7'h01;
    localparam logic [6:0] SLOT_MAX = 7'h63;

    // Reset values and writable mask bits
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [15:0] LEVEL_RST = 16'h0000;
    localparam logic [7:0] MASK_FIXED_BITS = 8'hBF;

    // Number of self subtests, cycles each
    localparam int TEST_COUNT = 4;
    localparam logic [2:0] TEST_LAST = 3'h3;

    // Operating mode encoding
    localparam logic MODE_VOLTAGE = 1'b0;
    localparam logic MODE_CURRENT = 1'b1;

    // Command request from the bus parser
    typedef struct packed {
        logic valid;
        logic [3:0] code;
        logic [15:0] arg_a;
        logic [15:0] arg_b;
        logic arg_mode;
    } ccsu_cmd_s;

    // Trigger settings held in a memory slot
    typedef struct packed {
        logic [15:0] volt;
        logic [15:0] curr;
        logic mode;
    } ccsu_trig_s;

    // Output stage programming
    typedef struct packed {
        logic enable;
        logic [15:0] volt;
        logic [15:0] curr;
        logic mode;
        logic range_auto;
    } ccsu_out_s;

    // Reply to the controller
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } ccsu_rsp_s;

    // Status sources of the summary byte
    typedef struct packed {
        logic operation_summary_bit;
        logic questionable_summary_bit;
        logic message_available_bit;
        logic errq;
        logic [7:0] event_bits;
        logic [7:0] event_enable;
    } ccsu_stat_s;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_TEST = 4'b0010,
        ST_WAIT = 4'b0100,
        ST_RECALL = 4'b1000
    } ccsu_state_e;
endpackage

// File: hdl/ccsu_slot_mem.sv
`timescale 1ns/1ps
module ccsu_slot_mem (
    input wire logic clock_i,                          // System clock
    input wire logic wr_i,                             // Write strobe
    input wire logic [6:0] addr_i,                     // Slot index
    input wire ccsu_pkg::ccsu_trig_s wdata_i,          // Settings to store
    output ccsu_pkg::ccsu_trig_s rdata_o               // Settings read, one cycle later
);
    import ccsu_pkg::*;

    // Storage for slots 1 to 99; slot 0 is never written
    ccsu_trig_s mem [0:127];

    // ------------------------------------------------
    // Write and registered read
    // ------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (wr_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end
endmodule

// File: hdl/ccsu_top.sv
`timescale 1ns/1ps
module ccsu_top (
    input wire logic clock_i,                          // 200 MHz system clock
    input wire logic sys_rst_i,                        // Power-on reset, sync, high
    input wire ccsu_pkg::ccsu_cmd_s cmd_i,             // Decoded command
    input wire logic listen_i,                         // Addressed as listener
    input wire logic poll_i,                           // Serial poll strobe
    input wire logic group_trig_i,                     // Bus group execute trigger
    input wire ccsu_pkg::ccsu_stat_s stat_i,           // Status sources
    input wire logic settle_i,                         // Output levels settled
    input wire logic [3:0] test_fail_i,                // Per-subtest fail flags
    input wire logic ov_i,                             // Overvoltage detected
    input wire logic oc_i,                             // Overcurrent detected
    output logic cmd_ready_o,                          // Ready for next command
    output ccsu_pkg::ccsu_rsp_s rsp_o,                 // Query reply
    output ccsu_pkg::ccsu_out_s out_o,                 // Output stage programming
    output logic ov_latch_o,                           // Overvoltage latched
    output logic oc_latch_o,                           // Overcurrent latched
    output logic wtg_o,                                // Waiting-for-trigger flag
    output logic srq_o                                 // Service request line
);
    import ccsu_pkg::*;

    typedef struct packed {
        ccsu_state_e state;
        logic ready;
        ccsu_rsp_s rsp;
        ccsu_out_s out;
        ccsu_trig_s trig;
        logic ov;
        logic oc;
        logic waiting_for_trigger_flag;
        logic cont;
        logic [7:0] mask;
        logic rqs;
        logic mss_prev;
        logic [2:0] test_idx;
        logic [7:0] test_code;
        logic recall_pend;
        logic [1:0] sync_ov;
        logic [1:0] sync_oc;
        logic [1:0] sync_settle;
    } ccsu_regs_s;

    ccsu_regs_s s_q;
    ccsu_regs_s s_d;
    ccsu_trig_s mem_rdata;
    logic mem_wr;
    logic [6:0] slot;
    logic [7:0] summary;
    logic mss;
    logic event_summary_bit;
    logic do_trig;

    // Slot index from the argument; out-of-range never writes
    function automatic logic slot_ok(input logic [15:0] arg);
        slot_ok = (arg >= 16'(SLOT_MIN)) && (arg <= 16'(SLOT_MAX));
    endfunction

    // ------------------------------------------------
    // Trigger settings memory
    // ------------------------------------------------
    assign slot = cmd_i.arg_a[6:0];
    assign mem_wr = s_q.ready && cmd_i.valid && (cmd_i.code == CMD_SAVE) && slot_ok(cmd_i.arg_a);

    ccsu_slot_mem u_mem (
        .clock_i(clock_i),
        .wr_i(mem_wr),
        .addr_i(slot),
        .wdata_i(s_q.trig),
        .rdata_o(mem_rdata)
    );

    // ------------------------------------------------
    // Summary byte
    // ------------------------------------------------
    // event summary from enabled events
    assign event_summary_bit = |(stat_i.event_bits & stat_i.event_enable);

    // masked bits OR into bit 6; bit 6 of mask is never set
    // master summary is purely combinational from current causes
    always_comb begin
        summary = 8'h00;
        // fixed bit layout, low two bits unused
        summary[SUM_OPERATION_SUMMARY_BIT_BIT] = stat_i.operation_summary_bit;
        summary[SUM_ESB_BIT] = event_summary_bit;
        summary[SUM_MAV_BIT] = stat_i.message_available_bit;
        summary[SUM_QUESTIONABLE_SUMMARY_BIT_BIT] = stat_i.questionable_summary_bit;
        summary[SUM_ERRQ_BIT] = stat_i.errq;
        mss = |(summary & s_q.mask);
        summary[SUM_MSS_BIT] = mss;
    end

    assign do_trig = listen_i && ((s_q.ready && cmd_i.valid && cmd_i.code == CMD_TRIGGER) || group_trig_i);

    // ------------------------------------------------
    // Next-state logic
    // ------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rsp.valid = 1'b0;
        // Synchronisers for pin-level inputs
        s_d.sync_ov = {s_q.sync_ov[0], ov_i};
        s_d.sync_oc = {s_q.sync_oc[0], oc_i};
        s_d.sync_settle = {s_q.sync_settle[0], settle_i};
        if (s_q.sync_ov[1]) begin
            s_d.ov = 1'b1;
        end
        if (s_q.sync_oc[1]) begin
            s_d.oc = 1'b1;
        end
        // Request flag rises on a new master summary; a poll clears it,
        // but a rise in the same cycle wins so no request is lost
        s_d.mss_prev = mss;
        // serial poll reports and clears request flag
        if (poll_i) begin
            s_d.rsp.valid = 1'b1;
            s_d.rsp.data = {summary[7], s_q.rqs, summary[5:0]};
            s_d.rqs = 1'b0;
        end
        if (mss && !s_q.mss_prev) begin
            s_d.rqs = 1'b1;
        end
        if (do_trig && s_q.waiting_for_trigger_flag) begin
            s_d.out.volt = s_q.trig.volt;
            s_d.out.curr = s_q.trig.curr;
            s_d.out.mode = s_q.trig.mode;
            s_d.waiting_for_trigger_flag = s_q.cont;
        end
        unique case (s_q.state)
            ST_IDLE: begin
                if (cmd_i.valid && s_q.ready) begin
                    unique case (cmd_i.code)
                        CMD_RESET: begin
                            // output off, zero levels, voltage mode
                            s_d.out.enable = 1'b0;
                            s_d.out.volt = LEVEL_RST;
                            s_d.out.curr = LEVEL_RST;
                            s_d.out.mode = MODE_VOLTAGE;
                            s_d.out.range_auto = 1'b1;
                            s_d.ov = 1'b0;
                            s_d.oc = 1'b0;
                            s_d.recall_pend = 1'b0;
                        end
                        CMD_RECALL: begin
                            // second recall moves trigger section to output
                            if (s_q.recall_pend) begin
                                s_d.out.volt = s_q.trig.volt;
                                s_d.out.curr = s_q.trig.curr;
                                s_d.out.mode = s_q.trig.mode;
                                s_d.recall_pend = 1'b0;
                            end else if (slot_ok(cmd_i.arg_a)) begin
                                s_d.state = ST_RECALL;
                                s_d.ready = 1'b0;
                            end
                        end
                        CMD_MASK_WR: begin
                            s_d.mask = cmd_i.arg_a[7:0] & MASK_FIXED_BITS;
                        end
                        CMD_MASK_RD: begin
                            s_d.rsp.valid = 1'b1;
                            s_d.rsp.data = s_q.mask;
                        end
                        CMD_STATUS_RD: begin
                            // summary with master bit, nothing cleared
                            s_d.rsp.valid = 1'b1;
                            s_d.rsp.data = summary;
                        end
                        CMD_SELF_TEST: begin
                            s_d.state = ST_TEST;
                            s_d.ready = 1'b0;
                            s_d.test_idx = 3'h0;
                            s_d.test_code = 8'h00;
                        end
                        CMD_WAIT: begin
                            s_d.state = ST_WAIT;
                            s_d.ready = 1'b0;
                        end
                        CMD_OUTPUT_ON: begin
                            s_d.out.enable = 1'b1;
                        end
                        CMD_INIT: begin
                            s_d.waiting_for_trigger_flag = 1'b1;
                            s_d.cont = cmd_i.arg_mode;
                        end
                        CMD_SET_TRIG: begin
                            s_d.trig.volt = cmd_i.arg_a;
                            s_d.trig.curr = cmd_i.arg_b;
                            s_d.trig.mode = cmd_i.arg_mode;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_TEST: begin
                if (test_fail_i[s_q.test_idx[1:0]]) begin
                    s_d.test_code = s_q.test_code | (8'h01 << s_q.test_idx);
                end
                s_d.test_idx = s_q.test_idx + 3'h1;
                if (s_q.test_idx == TEST_LAST) begin
                    s_d.rsp.valid = 1'b1;
                    s_d.rsp.data = s_d.test_code;
                    s_d.state = ST_IDLE;
                    s_d.ready = 1'b1;
                end
            end
            ST_WAIT: begin
                // release only once output levels settled
                if (s_q.sync_settle[1]) begin
                    s_d.state = ST_IDLE;
                    s_d.ready = 1'b1;
                end
            end
            ST_RECALL: begin
                s_d.trig = mem_rdata;
                s_d.recall_pend = 1'b1;
                s_d.state = ST_IDLE;
                s_d.ready = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------
    // State register
    // ------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
            s_q.state <= ST_IDLE;
            s_q.ready <= 1'b1;
            s_q.out.range_auto <= 1'b1;
            s_q.mask <= MASK_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flip-flops
    assign cmd_ready_o = s_q.ready;
    assign rsp_o = s_q.rsp;
    assign out_o = s_q.out;
    assign ov_latch_o = s_q.ov;
    assign oc_latch_o = s_q.oc;
    assign wtg_o = s_q.waiting_for_trigger_flag;
    assign srq_o = s_q.rqs;
endmodule

// File: tb/ccsu_top_chk.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the command unit
// ----------------------------------------
module ccsu_top_chk (
    input wire logic clock_i,                 // Clock
    input wire logic sys_rst_i,               // Reset
    input wire ccsu_pkg::ccsu_cmd_s cmd_i,    // Command
    input wire logic listen_i,                // Listener
    input wire logic poll_i,                  // Poll
    input wire logic group_trig_i,            // Group trigger
    input wire ccsu_pkg::ccsu_stat_s stat_i,  // Status
    input wire logic [3:0] test_fail_i,       // Test flags
    input wire logic cmd_ready_o,             // Ready
    input wire ccsu_pkg::ccsu_rsp_s rsp_o,    // Reply
    input wire ccsu_pkg::ccsu_out_s out_o,    // Output stage
    input wire logic ov_latch_o,              // OV latch
    input wire logic oc_latch_o,              // OC latch
    input wire logic wtg_o,                   // Waiting flag
    input wire logic srq_o                    // Request flag
);
    import ccsu_pkg::*;
    wire logic acc_w = cmd_i.valid && cmd_ready_o;
    logic [7:0] sum_w;
    logic [7:0] mask_q;
    // Summary byte without bit 6, rebuilt from the sources
    always_comb begin
        sum_w = {stat_i.operation_summary_bit, 1'h0, |(stat_i.event_bits & stat_i.event_enable),
                 stat_i.message_available_bit, stat_i.questionable_summary_bit, stat_i.errq, 2'h0};
    end
    // Shadow of the mask; a reset command leaves it alone
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            mask_q <= MASK_RST;
        end else if (acc_w && cmd_i.code == CMD_MASK_WR) begin
            mask_q <= cmd_i.arg_a[7:0] & MASK_FIXED_BITS;
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    a_reset_out_off: assert property (
        acc_w && cmd_i.code == CMD_RESET |=> !out_o.enable && out_o.volt == 16'h0 && out_o.curr == 16'h0
        && out_o.mode == MODE_VOLTAGE && out_o.range_auto) else $error("reset left output programmed");
    a_reset_fault_clr: assert property (
        acc_w && cmd_i.code == CMD_RESET |=> !ov_latch_o && !oc_latch_o) else $error("fault latch kept");
    a_mask_read: assert property (
        acc_w && cmd_i.code == CMD_MASK_RD |=> rsp_o.valid && rsp_o.data == mask_q) else $error("mask reply");
    a_status_byte: assert property (
        acc_w && cmd_i.code == CMD_STATUS_RD |=> rsp_o.valid
        && rsp_o.data == ($past(sum_w) | ({7'h0, |($past(sum_w) & mask_q)} << 6))) else $error("status reply");
    a_poll_flag: assert property (
        poll_i |=> rsp_o.valid && rsp_o.data[6] == $past(srq_o)) else $error("poll reply");
    a_self_test: assert property (
        acc_w && cmd_i.code == CMD_SELF_TEST |=> !cmd_ready_o ##[1:5]
        (rsp_o.valid && rsp_o.data == {4'h0, test_fail_i})) else $error("self test reply");
    a_wait_hold: assert property (
        acc_w && cmd_i.code == CMD_WAIT |=> !cmd_ready_o [*2]) else $error("wait released early");
    a_trig_listen: assert property (
        ((acc_w && cmd_i.code == CMD_TRIGGER) || group_trig_i) && !listen_i
        |=> $stable(wtg_o) && $stable(out_o.volt)) else $error("trigger taken unaddressed");
endmodule
bind ccsu_top ccsu_top_chk u_ccsu_top_chk (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .cmd_i(cmd_i),
    .listen_i(listen_i), .poll_i(poll_i), .group_trig_i(group_trig_i), .stat_i(stat_i),
    .test_fail_i(test_fail_i), .cmd_ready_o(cmd_ready_o), .rsp_o(rsp_o), .out_o(out_o),
    .ov_latch_o(ov_latch_o), .oc_latch_o(oc_latch_o), .wtg_o(wtg_o), .srq_o(srq_o));

// File: tb/ccsu_ctl_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Remote controller issuing commands
// ----------------------------------------
module ccsu_ctl_model (
    input wire logic clock_i,          // Clock
    input wire logic ready_i,          // Unit ready
    output ccsu_pkg::ccsu_cmd_s cmd_o  // Command
);
    import ccsu_pkg::*;
    initial cmd_o = '0;
    // Ready is read at a falling edge so a command taken at this edge is seen
    task automatic send(input logic [3:0] code, input logic [15:0] a, input logic [15:0] b, input logic m);
        ccsu_cmd_s c;
        c = '{1'h1, code, a, b, m};
        @(negedge clock_i);
        for (int i = 0; i < 400 && ready_i !== 1'h1; i++) begin
            @(negedge clock_i);
        end
        @(posedge clock_i);
        cmd_o <= c;
        @(posedge clock_i);
        cmd_o <= {1'h0, ~c[36:0]};
    endtask
endmodule

// File: tb/common_command_status_unit_tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------
// Testbench for the command and status unit
// ----------------------------------------
module common_command_status_unit_tb_top;
    import ccsu_pkg::*;
    logic clock_i, sys_rst_i, listen_i, poll_i, group_trig_i, settle_i, ov_i, oc_i;
    logic cmd_ready_o, ov_latch_o, oc_latch_o, wtg_o, srq_o;
    logic [3:0] test_fail_i;
    logic [7:0] d;
    ccsu_stat_s stat_i;
    ccsu_cmd_s cmd_w;
    ccsu_rsp_s rsp_o;
    ccsu_out_s out_o;
    int err_count = 0;
    int n_compared = 0;
    logic [3:0] tf[2] = '{4'hA, 4'h0};
    ccsu_top u_ccsu_top (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .cmd_i(cmd_w), .listen_i(listen_i),
        .poll_i(poll_i), .group_trig_i(group_trig_i), .stat_i(stat_i), .settle_i(settle_i),
        .test_fail_i(test_fail_i), .ov_i(ov_i), .oc_i(oc_i), .cmd_ready_o(cmd_ready_o), .rsp_o(rsp_o),
        .out_o(out_o), .ov_latch_o(ov_latch_o), .oc_latch_o(oc_latch_o), .wtg_o(wtg_o), .srq_o(srq_o));
    ccsu_ctl_model u_ccsu_ctl_model (.clock_i(clock_i), .ready_i(cmd_ready_o), .cmd_o(cmd_w));
    // 200 MHz clock
    initial begin
        clock_i = 1'h0;
        forever #2.5 clock_i = ~clock_i;
    end
    task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Commands leave a few cycles for levels to land
    task automatic cmd(input logic [3:0] c, input logic [15:0] a = 16'h0, input logic [15:0] b = 16'h0,
                       input logic m = 1'h0);
        u_ccsu_ctl_model.send(c, a, b, m);
        repeat (3) @(negedge clock_i);
    endtask
    // Reply stands one cycle, so it is looked for at every falling edge
    task automatic ask(input logic [3:0] c);
        d = 8'hXX;
        u_ccsu_ctl_model.send(c, 16'h0, 16'h0, 1'h0);
        for (int i = 0; i < 12; i++) begin
            @(negedge clock_i);
            if (rsp_o.valid === 1'h1) begin
                d = rsp_o.data;
                break;
            end
        end
    endtask
    // Poll reply stands only in the cycle after the poll edge
    task automatic poll();
        @(posedge clock_i);
        poll_i <= 1'h1;
        @(posedge clock_i);
        poll_i <= 1'h0;
        @(negedge clock_i);
        d = (rsp_o.valid === 1'h1) ? rsp_o.data : 8'hXX;
    endtask
    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Whole run is well under a few hundred cycles
    initial begin
        #20000;
        err_count++;
        close_out();
    end
    initial begin
        sys_rst_i = 1'h1;
        {listen_i, poll_i, group_trig_i, ov_i, oc_i} = 5'h00;
        settle_i = 1'h1;
        test_fail_i = 4'h0;
        stat_i = '0;
        repeat (5) @(posedge clock_i);
        sys_rst_i <= 1'h0;
        @(negedge clock_i);
        chk("out at start", {1'h0, 32'h0, MODE_VOLTAGE, 1'h1}, out_o);
        ask(CMD_MASK_RD);
        chk("mask at start", 8'h00, d);
        cmd(CMD_MASK_WR, 16'h00FF);
        ask(CMD_MASK_RD);
        chk("mask bit 6", 8'hBF, d);
        cmd(CMD_MASK_WR, 16'h0028);
        ask(CMD_MASK_RD);
        chk("mask", 8'h28, d);
        @(posedge clock_i);
        stat_i <= '{1'h1, 1'h0, 1'h1, 1'h1, 8'h20, 8'h20};
        ask(CMD_STATUS_RD);
        chk("status", 8'hF4, d);
        poll();
        chk("poll", 8'hF4, d);
        poll();
        chk("poll cleared", 8'hB4, d);
        ask(CMD_STATUS_RD);
        chk("status kept", 8'hF4, d);
        @(posedge clock_i);
        stat_i.event_enable <= 8'h00;
        ask(CMD_STATUS_RD);
        chk("status no event", 8'h94, d);
        cmd(CMD_SET_TRIG, 16'h1234, 16'h0056, 1'h1);
        cmd(CMD_INIT);
        chk("armed", 1'h1, wtg_o);
        cmd(CMD_TRIGGER);
        chk("unaddressed", {1'h1, 16'h0}, {wtg_o, out_o.volt});
        @(posedge clock_i);
        listen_i <= 1'h1;
        cmd(CMD_TRIGGER);
        chk("trigger", {1'h0, 16'h1234, 16'h0056}, {wtg_o, out_o.volt, out_o.curr});
        cmd(CMD_SET_TRIG, 16'h0777, 16'h0088, 1'h1);
        cmd(CMD_INIT, 16'h0, 16'h0, 1'h1);
        @(posedge clock_i);
        group_trig_i <= 1'h1;
        @(posedge clock_i);
        group_trig_i <= 1'h0;
        repeat (2) @(negedge clock_i);
        chk("group trigger", {1'h1, 16'h0777}, {wtg_o, out_o.volt});
        cmd(CMD_SAVE, 16'h0063);
        cmd(CMD_SET_TRIG, 16'h0ABC, 16'h0DEF, 1'h0);
        // Move the output away from the saved levels so recall must restore them
        cmd(CMD_TRIGGER);
        chk("retrigger", {16'h0ABC, 16'h0DEF}, {out_o.volt, out_o.curr});
        cmd(CMD_RECALL, 16'h0063);
        cmd(CMD_RECALL, 16'h0063);
        chk("recall", {16'h0777, 16'h0088}, {out_o.volt, out_o.curr});
        cmd(CMD_OUTPUT_ON);
        @(posedge clock_i);
        {ov_i, oc_i} <= 2'h3;
        repeat (6) @(posedge clock_i);
        {ov_i, oc_i} <= 2'h0;
        @(negedge clock_i);
        chk("faults latched", 2'h3, {ov_latch_o, oc_latch_o});
        cmd(CMD_RESET);
        chk("reset out", {1'h0, 32'h0, MODE_VOLTAGE, 1'h1}, out_o);
        chk("faults cleared", 2'h0, {ov_latch_o, oc_latch_o});
        for (int k = 0; k < 2; k++) begin
            @(posedge clock_i);
            test_fail_i <= tf[k];
            ask(CMD_SELF_TEST);
            chk("self test", {4'h0, tf[k]}, d);
        end
        @(posedge clock_i);
        settle_i <= 1'h0;
        cmd(CMD_WAIT);
        repeat (4) @(negedge clock_i);
        chk("wait holds", 1'h0, cmd_ready_o);
        @(posedge clock_i);
        settle_i <= 1'h1;
        ask(CMD_MASK_RD);
        chk("after wait", 8'h28, d);
        close_out();
    end
endmodule
